// *** rtl/pir_relocator.sv ***
// Page index relocator: address translation, write protection, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pir_params.svh"

module pir_relocator (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] axi_awaddr_i,
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  output logic [1:0] axi_bresp_o,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  input wire logic [7:0] axi_araddr_i,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  input wire logic ref_req_i,
  input wire logic [14:0] ref_addr_i,
  input wire logic ref_write_i,
  input wire logic ref_fetch_i,
  input wire logic ref_io_i,
  input wire logic enter_program_i,
  input wire logic return_monitor_i,
  input wire logic reloc_operand_i,
  input wire logic reloc_instr_i,
  output logic [17:0] phys_addr_o,
  output logic left_bus_req_o,
  output logic right_bus_req_o,
  output logic store_write_o,
  output logic illegal_write_o,
  output logic ref_done_o,
  output logic monitor_state_o
);
  import pir_pkg::*;

  localparam pir_regs_s REGS_RST = '{
    monitor: `PIR_MONITOR_RST,
    instruction_state_reg: `PIR_INSTR_STATE_RST,
    operand_state_reg: `PIR_OPND_STATE_RST,
    index: `PIR_INDEX_RST,
    default: '0
  };

  pir_regs_s r_reg;
  pir_regs_s r_next;
  pir_file_if fif ();

  pir_page_file u_file (
    .core_clk_i(core_clk_i),
    .fp(fif.mem)
  );

  // Byte strobes merge new bytes into the current register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    pir_state_num_t st;
    logic wr_fire;
    logic [31:0] wval;
    logic [31:0] rval;
    logic rerr;
    logic clr_illegal;
    pir_entry_s ent;
    logic [11:0] half;
    logic [1:0] qsum;
    logic unaddr;
    logic ro_hit;
    logic range_hit;
    logic bad;
    logic access;
    r_next = r_reg;
    st = '0;
    wr_fire = 1'b0;
    wval = '0;
    rval = '0;
    rerr = 1'b0;
    clr_illegal = 1'b0;
    ent = '0;
    half = '0;
    qsum = '0;
    unaddr = 1'b0;
    ro_hit = 1'b0;
    range_hit = 1'b0;
    bad = 1'b0;
    access = 1'b0;
    // Port B follows the software index and is written only by an entry write
    fif.we_b = 2'h0;
    fif.addr_b = r_reg.index[6:1];
    fif.wdata_b = '0;

    // Processor state tracking; a return to monitor wins over everything
    if (return_monitor_i) begin
      r_next.monitor = 1'b1;
      r_next.operand_mode = 1'b0;
    end else begin
      // Entering program state keeps the operand mode as it was
      if (enter_program_i) begin
        r_next.monitor = 1'b0;
      end
      if (reloc_operand_i) begin
        r_next.operand_mode = 1'b1;
      end else if (reloc_instr_i) begin
        r_next.operand_mode = 1'b0;
      end
    end

    // State number for the incoming reference
    // Port A is addressed now so the entry arrives with the registered request
    if (ref_fetch_i) begin
      st = r_reg.monitor ? 3'h0 : r_reg.instruction_state_reg;
    end else if (r_reg.operand_mode) begin
      st = r_reg.operand_state_reg;
    end else begin
      st = r_reg.monitor ? 3'h0 : r_reg.instruction_state_reg;
    end
    fif.addr_a = {st, ref_addr_i[14:12]};
    r_next.p_valid = ref_req_i;
    // Qualifiers are captured only with a request
    if (ref_req_i) begin
      r_next.p_addr = ref_addr_i;
      r_next.p_write = ref_write_i;
      r_next.p_check_range = !r_reg.monitor && !ref_io_i;
      r_next.p_zero = (st == 3'h0) && (ref_addr_i[14:11] == 4'h0);
    end

    // AXI write channel, address and data taken in either order
    if (axi_awvalid_i && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = axi_awaddr_i;
    end
    if (axi_wvalid_i && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.wdata = axi_wdata_i;
      r_next.wstrb = axi_wstrb_i;
    end
    if (r_reg.bvalid && axi_bready_i) begin
      r_next.bvalid = 1'b0;
    end
    // The register write lands one cycle after both address and data are held
    wr_fire = r_reg.aw_have && r_reg.w_have && !r_reg.bvalid;
    if (wr_fire) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `PIR_RESP_OKAY;
      unique case ({r_reg.awaddr[7:2], 2'b00})
        `PIR_OFF_INSTR_STATE: begin
          wval = merge_bytes({29'h0, r_reg.instruction_state_reg}, r_reg.wdata, r_reg.wstrb);
          r_next.instruction_state_reg = wval[2:0];
        end
        `PIR_OFF_OPND_STATE: begin
          wval = merge_bytes({29'h0, r_reg.operand_state_reg}, r_reg.wdata, r_reg.wstrb);
          r_next.operand_state_reg = wval[2:0];
        end
        `PIR_OFF_MODE: begin
          clr_illegal = r_reg.wstrb[0] && r_reg.wdata[`PIR_MODE_ILLEGAL_BIT];
        end
        `PIR_OFF_INDEX: begin
          wval = merge_bytes({25'h0, r_reg.index}, r_reg.wdata, r_reg.wstrb);
          r_next.index = wval[6:0];
        end
        `PIR_OFF_ENTRY: begin
          wval = merge_bytes({20'h0, r_reg.index[0] ? fif.rdata_b[23:12] : fif.rdata_b[11:0]},
            r_reg.wdata, r_reg.wstrb);
          fif.wdata_b = {wval[11:0], wval[11:0]};
          // Only the addressed half is written; the other entry is kept
          fif.we_b = r_reg.index[0] ? 2'h2 : 2'h1;
        end
        `PIR_OFF_LAST: begin
          r_next.bresp = `PIR_RESP_OKAY;
        end
        default: begin
          r_next.bresp = `PIR_RESP_SLVERR;
        end
      endcase
    end
    // A channel is ready again once its held item and the response are gone
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready = !r_next.w_have && !r_next.bvalid;

    // AXI read channel, one cycle from address to data
    // Unmapped offsets answer SLVERR with zero data
    if (r_reg.rvalid && axi_rready_i) begin
      r_next.rvalid = 1'b0;
    end
    if (axi_arvalid_i && r_reg.arready) begin
      unique case ({axi_araddr_i[7:2], 2'b00})
        `PIR_OFF_INSTR_STATE: rval = {29'h0, r_reg.instruction_state_reg};
        `PIR_OFF_OPND_STATE: rval = {29'h0, r_reg.operand_state_reg};
        `PIR_OFF_MODE: rval = {29'h0, r_reg.illegal_seen, r_reg.operand_mode, r_reg.monitor};
        `PIR_OFF_INDEX: rval = {25'h0, r_reg.index};
        `PIR_OFF_ENTRY: rval = {20'h0, r_reg.index[0] ? fif.rdata_b[23:12] : fif.rdata_b[11:0]};
        `PIR_OFF_LAST: rval = {14'h0, r_reg.last_addr};
        default: rerr = 1'b1;
      endcase
      r_next.rvalid = 1'b1;
      r_next.rdata = rval;
      r_next.rresp = rerr ? `PIR_RESP_SLVERR : `PIR_RESP_OKAY;
    end
    // One read at a time: no new address while data wait
    r_next.arready = !r_next.rvalid;

    // Translation of the reference taken last cycle
    // Results show at the second edge after the request: file read, then decode
    half = r_reg.p_addr[11] ? fif.rdata_a[23:12] : fif.rdata_a[11:0];
    ent = pir_entry_s'(half);
    if (r_reg.p_zero) begin
      ent.page_address_field = 7'h00;
      ent.partial_page_field = 2'h0;
    end
    qsum = ent.partial_page_field + r_reg.p_addr[10:9];
    // Unaddressable test sees the fields after page zero forcing
    unaddr = ent.excl && (ent.page_length_field == 2'h0)
      && (ent.page_address_field == 7'h00) && (ent.partial_page_field == 2'h0);
    ro_hit = ent.excl && !unaddr && r_reg.p_write;
    // Range check uses the program quarter, not the physical one
    range_hit = r_reg.p_check_range && (ent.page_length_field != 2'h0)
      && (r_reg.p_addr[10:9] >= ent.page_length_field);
    bad = r_reg.p_valid && (unaddr || ro_hit || range_hit);
    access = r_reg.p_valid && !bad;
    r_next.done = r_reg.p_valid;
    r_next.illegal = bad;
    // Top page bit is physical bit 17 and picks the storage bus
    r_next.left_req = access && ent.page_address_field[6];
    r_next.right_req = access && !ent.page_address_field[6];
    r_next.store_we = access && r_reg.p_write;
    if (r_reg.p_valid) begin
      r_next.phys = {ent.page_address_field, qsum, r_reg.p_addr[8:0]};
      r_next.last_addr = r_next.phys;
    end

    // Sticky illegal flag: a new event wins over a software clear
    r_next.illegal_seen = (r_reg.illegal_seen && !clr_illegal) || bad;
  end

  // Reset leaves the page file contents as they were
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Every output is a register bit
  assign axi_awready_o = r_reg.awready;
  assign axi_wready_o = r_reg.wready;
  assign axi_bresp_o = r_reg.bresp;
  assign axi_bvalid_o = r_reg.bvalid;
  assign axi_arready_o = r_reg.arready;
  assign axi_rdata_o = r_reg.rdata;
  assign axi_rresp_o = r_reg.rresp;
  assign axi_rvalid_o = r_reg.rvalid;
  assign phys_addr_o = r_reg.phys;
  assign left_bus_req_o = r_reg.left_req;
  assign right_bus_req_o = r_reg.right_req;
  assign store_write_o = r_reg.store_we;
  assign illegal_write_o = r_reg.illegal;
  assign ref_done_o = r_reg.done;
  assign monitor_state_o = r_reg.monitor;
endmodule
`default_nettype wire

// *** rtl/pir_params.svh ***
// Offsets, field positions, reset values and codes of the page index relocator
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

`define PIR_ADDR_W 8
`define PIR_OFF_INSTR_STATE 8'h00
`define PIR_OFF_OPND_STATE 8'h04
`define PIR_OFF_MODE 8'h08
`define PIR_OFF_INDEX 8'h0C
`define PIR_OFF_ENTRY 8'h10
`define PIR_OFF_LAST 8'h14

`define PIR_MODE_MONITOR_BIT 0
`define PIR_MODE_OPERAND_BIT 1
`define PIR_MODE_ILLEGAL_BIT 2

`define PIR_ENTRY_W 12
`define PIR_WORD_W 24
`define PIR_WORDS 64
`define PIR_WADDR_W 6
`define PIR_EXCL_BIT 11
`define PIR_LEN_LSB 9
`define PIR_PAGE_FLD_LSB 2
`define PIR_PART_LSB 0

`define PIR_PADDR_W 15
`define PIR_PHYS_W 18
`define PIR_QTR_LSB 9
`define PIR_PAGE_LSB 12
`define PIR_HALF_BIT 11

`define PIR_INSTR_STATE_RST 3'h0
`define PIR_OPND_STATE_RST 3'h0
`define PIR_INDEX_RST 7'h00
`define PIR_MONITOR_RST 1'h1

`define PIR_RESP_OKAY 2'h0
`define PIR_RESP_SLVERR 2'h2

`endif

// *** rtl/pir_pkg.sv ***
// Types of the page index relocator
`default_nettype none
package pir_pkg;
  `include "pir_params.svh"

  typedef logic [2:0] pir_state_num_t;

  // Field order gives excl at 11, length at 10:9, page at 8:2, partial at 1:0
  typedef struct packed {
    logic excl;
    logic [1:0] page_length_field;
    logic [6:0] page_address_field;
    logic [1:0] partial_page_field;
  } pir_entry_s;

  typedef struct packed {
    logic monitor;
    logic operand_mode;
    pir_state_num_t instruction_state_reg;
    pir_state_num_t operand_state_reg;
    logic [6:0] index;
    logic illegal_seen;
    logic [17:0] last_addr;
    logic p_valid;
    logic p_write;
    logic p_check_range;
    logic p_zero;
    logic [14:0] p_addr;
    logic [17:0] phys;
    logic left_req;
    logic right_req;
    logic store_we;
    logic illegal;
    logic done;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pir_regs_s;
endpackage
`default_nettype wire

// *** rtl/pir_file_if.sv ***
// Ports between the relocator and its page index file memory
`timescale 1ns/1ps
`default_nettype none
interface pir_file_if;
  logic [5:0] addr_a;
  logic [23:0] rdata_a;
  logic [5:0] addr_b;
  logic [1:0] we_b;
  logic [23:0] wdata_b;
  logic [23:0] rdata_b;

  modport mem (input addr_a, output rdata_a, input addr_b, input we_b, input wdata_b,
    output rdata_b);
  modport user (output addr_a, input rdata_a, output addr_b, output we_b, output wdata_b,
    input rdata_b);
endinterface
`default_nettype wire

// *** rtl/pir_page_file.sv ***
// Page index file: 64 words of two 12-bit entries, registered read on two ports
`timescale 1ns/1ps
`default_nettype none
module pir_page_file (
  input wire logic core_clk_i,
  pir_file_if.mem fp
);
  import pir_pkg::*;

  // Each half of a word is an array of its own, written by one process only
  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      logic [11:0] mem [0:63];
      logic [11:0] rdata_a_reg;
      logic [11:0] rdata_b_reg;
      always_ff @(posedge core_clk_i) begin
        if (fp.we_b[h]) begin
          mem[fp.addr_b] <= fp.wdata_b[h*12 +: 12];
        end
        rdata_a_reg <= mem[fp.addr_a];
        rdata_b_reg <= mem[fp.addr_b];
      end
      assign fp.rdata_a[h*12 +: 12] = rdata_a_reg;
      assign fp.rdata_b[h*12 +: 12] = rdata_b_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// *** dv/pir_cpu_model.sv ***
// Processor address path model: storage references and state-change pulses
`timescale 1ns/1ps
`default_nettype none
module pir_cpu_model (
  input wire logic core_clk_i,
  output logic ref_req_o,
  output logic [14:0] ref_addr_o,
  output logic [2:0] kind_o,
  output logic [3:0] ctl_o
);
  initial begin
    {ref_req_o, ref_addr_o, kind_o, ctl_o} = {1'b0, 15'h5555, 3'h2, 4'h0};
  end
  // Kind is {write, fetch, io}; released lines flip so a stale value cannot pass
  task automatic issue(input logic [14:0] a, input logic [2:0] k);
    @(posedge core_clk_i);
    {ref_req_o, ref_addr_o, kind_o} <= {1'b1, a, k};
    @(posedge core_clk_i);
    {ref_req_o, ref_addr_o, kind_o} <= {1'b0, ~a, ~k};
  endtask
  // Control is {to instruction, to operand, to monitor, enter program}
  task automatic pulse(input logic [3:0] c);
    @(posedge core_clk_i);
    ctl_o <= c;
    @(posedge core_clk_i);
    ctl_o <= 4'h0;
    @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// *** dv/pir_relocator_properties.sv ***
// Checker of the relocator's reference results
`timescale 1ns/1ps
`default_nettype none
module pir_relocator_properties (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_req_i,
  input wire logic [14:0] ref_addr_i,
  input wire logic ref_write_i,
  input wire logic ref_fetch_i,
  input wire logic return_monitor_i,
  input wire logic [17:0] phys_addr_o,
  input wire logic left_bus_req_o,
  input wire logic right_bus_req_o,
  input wire logic store_write_o,
  input wire logic illegal_write_o,
  input wire logic ref_done_o,
  input wire logic monitor_state_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_done;
    ref_req_i |-> ##2 ref_done_o;
  endproperty
  a_done: assert property (p_done) else $error("result missing");
  property p_cause;
    ref_done_o |-> $past(ref_req_i, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("result without request");
  property p_one_path;
    ref_done_o |-> $onehot({left_bus_req_o, right_bus_req_o, illegal_write_o});
  endproperty
  a_one_path: assert property (p_one_path) else $error("not one outcome");
  property p_block;
    illegal_write_o |-> !left_bus_req_o && !right_bus_req_o && !store_write_o;
  endproperty
  a_block: assert property (p_block) else $error("illegal access not blocked");
  property p_bus;
    left_bus_req_o || right_bus_req_o |-> left_bus_req_o == phys_addr_o[17];
  endproperty
  a_bus: assert property (p_bus) else $error("wrong bus");
  property p_low_bits;
    ref_req_i ##2 !illegal_write_o |-> phys_addr_o[8:0] == $past(ref_addr_i[8:0], 2);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits altered");
  property p_store;
    store_write_o |-> $past(ref_req_i && ref_write_i, 2);
  endproperty
  a_store: assert property (p_store) else $error("store without write");
  property p_page_zero;
    ref_req_i && ref_fetch_i && monitor_state_o && ref_addr_i[14:11] == 4'h0
      ##2 !illegal_write_o |-> phys_addr_o[17:9] == {7'h00, $past(ref_addr_i[10:9], 2)};
  endproperty
  a_page_zero: assert property (p_page_zero) else $error("page zero moved");
  property p_monitor;
    return_monitor_i |=> monitor_state_o;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor not entered");
  c_illegal: cover property (illegal_write_o);
  c_left_store: cover property (left_bus_req_o && store_write_o);
  c_right: cover property (right_bus_req_o);
endmodule
bind pir_relocator pir_relocator_properties pir_relocator_properties_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ref_req_i(ref_req_i),
  .ref_addr_i(ref_addr_i), .ref_write_i(ref_write_i), .ref_fetch_i(ref_fetch_i),
  .return_monitor_i(return_monitor_i), .phys_addr_o(phys_addr_o),
  .left_bus_req_o(left_bus_req_o), .right_bus_req_o(right_bus_req_o),
  .store_write_o(store_write_o), .illegal_write_o(illegal_write_o),
  .ref_done_o(ref_done_o), .monitor_state_o(monitor_state_o)
);
`default_nettype wire

// *** dv/pir_relocator_bench.sv ***
// Self-checking bench of the page index relocator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pir_relocator_bench;
  logic core_clk_i, sys_rst_i, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv;
  logic req, lft, rgt, stw, ill, done, mon;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [14:0] addr;
  logic [2:0] kind;
  logic [3:0] ctl;
  logic [17:0] phys;
  int num_errors, comparisons;
  pir_relocator pir_relocator_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .axi_awaddr_i(awa), .axi_awvalid_i(awv),
    .axi_awready_o(awr), .axi_wdata_i(wd), .axi_wstrb_i(4'hF), .axi_wvalid_i(wv),
    .axi_wready_o(wrd), .axi_bresp_o(br), .axi_bvalid_o(bv), .axi_bready_i(bre),
    .axi_araddr_i(ara), .axi_arvalid_i(arv), .axi_arready_o(arr), .axi_rdata_o(rd),
    .axi_rresp_o(rr), .axi_rvalid_o(rv), .axi_rready_i(rre), .ref_req_i(req),
    .ref_addr_i(addr), .ref_write_i(kind[2]), .ref_fetch_i(kind[1]), .ref_io_i(kind[0]),
    .enter_program_i(ctl[0]), .return_monitor_i(ctl[1]), .reloc_operand_i(ctl[2]),
    .reloc_instr_i(ctl[3]), .phys_addr_o(phys), .left_bus_req_o(lft), .right_bus_req_o(rgt),
    .store_write_o(stw), .illegal_write_o(ill), .ref_done_o(done), .monitor_state_o(mon)
  );
  pir_cpu_model pir_cpu_model_i (
    .core_clk_i(core_clk_i), .ref_req_o(req), .ref_addr_o(addr), .kind_o(kind), .ctl_o(ctl)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) break;
    end
    bre <= 1'b0;
    if (n == 40) begin `CHK(1'b0, 1'b1) stop_test(); end
    `CHK(br, er)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    {ara, arv, rre} <= {a, 2'b11};
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rre <= 1'b0;
    if (n == 40) begin `CHK(1'b0, 1'b1) stop_test(); end
    `CHK(rd, ed)
    `CHK(rr, er)
  endtask
  task automatic put(input logic [6:0] i, input logic [11:0] e);
    wr(8'h0C, {25'h0, i}, 2'h0);
    wr(8'h10, {20'h0, e}, 2'h0);
  endtask
  // Expected flags are {done, illegal, left, right, store}
  task automatic ref_chk(input logic [14:0] a, input logic [2:0] k, input logic [4:0] ef,
      input logic [17:0] ep);
    pir_cpu_model_i.issue(a, k);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CHK({done, ill, lft, rgt, stw}, ef)
    if (!ef[3]) `CHK(phys, ep)
  endtask
  task automatic t_regs;
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h04, 32'h0, 2'h0);
    rd_chk(8'h08, 32'h1, 2'h0);
    rd_chk(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'h5, 2'h2);
    wr(8'h00, 32'h2, 2'h0);
    wr(8'h04, 32'h3, 2'h0);
    rd_chk(8'h00, 32'h2, 2'h0);
    $display("register test done");
  endtask
  task automatic t_map;
    put(7'h25, 12'h115);
    put(7'h24, 12'h04A);
    wr(8'h0C, 32'h25, 2'h0);
    rd_chk(8'h10, 32'h115, 2'h0);
    put(7'h26, 12'h81C);
    put(7'h27, 12'h800);
    put(7'h28, 12'h380);
    put(7'h30, 12'h004);
    put(7'h00, 12'h1FF);
    rd_chk(8'h10, 32'h1FF, 2'h0);
    $display("entry test done");
  endtask
  task automatic t_xlate;
    pir_cpu_model_i.pulse(4'h1);
    `CHK(mon, 1'b0)
    ref_chk(15'h2EAB, 3'b100, 5'h15, 18'h228AB);
    ref_chk(15'h23FF, 3'b000, 5'h12, 18'h097FF);
    rd_chk(8'h14, 32'h97FF, 2'h0);
    $display("translate test done");
  endtask
  task automatic t_protect;
    ref_chk(15'h3010, 3'b000, 5'h12, 18'h03810);
    ref_chk(15'h3010, 3'b100, 5'h18, 18'h0);
    rd_chk(8'h08, 32'h4, 2'h0);
    wr(8'h08, 32'h4, 2'h0);
    rd_chk(8'h08, 32'h0, 2'h0);
    ref_chk(15'h3800, 3'b000, 5'h18, 18'h0);
    ref_chk(15'h4200, 3'b000, 5'h18, 18'h0);
    ref_chk(15'h4200, 3'b001, 5'h14, 18'h30200);
    ref_chk(15'h4005, 3'b100, 5'h15, 18'h30005);
    $display("protect test done");
  endtask
  task automatic t_modes;
    pir_cpu_model_i.pulse(4'h4);
    ref_chk(15'h0007, 3'b000, 5'h12, 18'h00807);
    ref_chk(15'h2EAB, 3'b010, 5'h14, 18'h228AB);
    pir_cpu_model_i.pulse(4'h8);
    ref_chk(15'h2EAB, 3'b000, 5'h14, 18'h228AB);
    pir_cpu_model_i.pulse(4'h2);
    `CHK(mon, 1'b1)
    ref_chk(15'h07C0, 3'b100, 5'h13, 18'h007C0);
    ref_chk(15'h07C0, 3'b010, 5'h12, 18'h007C0);
    $display("mode test done");
  endtask
  initial begin
    num_errors = 0;
    comparisons = 0;
    sys_rst_i = 1'b1;
    {awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    t_regs();
    t_map();
    t_xlate();
    t_protect();
    t_modes();
    stop_test();
  end
endmodule
`default_nettype wire
